// ==== design/rsse_pkg.sv ====
package rsse_pkg;

    // operations accepted on the execute port
    typedef enum logic [4:0] {
        RSSE_OP_NOP         = 5'h00,
        RSSE_OP_ROTL_ACC    = 5'h01,
        RSSE_OP_ROTLC       = 5'h02,
        RSSE_OP_ROTLC_ACC   = 5'h03,
        RSSE_OP_ROTR        = 5'h04,
        RSSE_OP_ROTR_ACC    = 5'h05,
        RSSE_OP_ROTRC       = 5'h06,
        RSSE_OP_ROTRC_ACC   = 5'h07,
        RSSE_OP_SBC_MEM     = 5'h08,
        RSSE_OP_SBC_IMM     = 5'h09,
        RSSE_OP_SBC_TO_MEM  = 5'h0a,
        RSSE_OP_SUB_MEM     = 5'h0b,
        RSSE_OP_DSZ         = 5'h0c,
        RSSE_OP_DSZ_ACC     = 5'h0d,
        RSSE_OP_ISZ         = 5'h0e,
        RSSE_OP_ISZ_ACC     = 5'h0f,
        RSSE_OP_SNZ_BIT     = 5'h10,
        RSSE_OP_SNZ_BYTE    = 5'h11,
        RSSE_OP_SET_BYTE    = 5'h12,
        RSSE_OP_SET_BIT     = 5'h13
    } rsse_op_t;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
        logic sc;
        logic cz;
    } rsse_flags_t;

    typedef struct packed {
        rsse_op_t   op;
        logic [2:0] bit_sel;
        logic [7:0] mem_data;
        logic [7:0] imm;
    } rsse_req_t;

    // execution sequencer, gray coded
    typedef enum logic [1:0] {
        RSSE_ST_EXEC  = 2'b00,
        RSSE_ST_DUMMY = 2'b01
    } rsse_state_t;

    localparam logic [1:0]  RSSE_OFS_ACC   = 2'h0;
    localparam logic [1:0]  RSSE_OFS_FLAGS = 2'h1;
    localparam logic [7:0]  RSSE_ACC_RST   = 8'h00;
    localparam rsse_flags_t RSSE_FLAGS_RST = 6'h00;
    localparam logic [7:0]  RSSE_ALL_ONES  = 8'hff;
    localparam int          RSSE_TOP_BIT   = 7;
    localparam int          RSSE_HALF_BIT  = 4;
    localparam int          RSSE_SKIP_CYCLES = 2;

endpackage : rsse_pkg

// ==== design/rsse_exec.sv ====
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rsse_exec
    import rsse_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        exec_valid_i,
    input  wire rsse_req_t   exec_req_i,
    output logic             exec_ready_o,
    output logic             mem_we_o,
    output logic [7:0]       mem_wdata_o,
    output logic             skip_o,
    output logic [7:0]       acc_o,
    output rsse_flags_t      flags_o,
    input  wire logic [1:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [7:0]       reg_rdata_o
);

    rsse_state_t state_q;
    rsse_state_t state_d;
    logic [7:0]  acc_q;
    logic [7:0]  acc_d;
    rsse_flags_t flags_q;
    rsse_flags_t flags_d;
    logic        mem_we_q;
    logic        mem_we_d;
    logic [7:0]  mem_wdata_q;
    logic [7:0]  mem_wdata_d;
    logic        skip_q;
    logic        skip_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;

    wire logic       take      = exec_valid_i && (state_q == RSSE_ST_EXEC);
    wire logic [7:0] m         = exec_req_i.mem_data;
    wire logic [7:0] bit_mask  = 8'h01 << exec_req_i.bit_sel;
    wire logic [7:0] dec_val   = m - 8'h01;
    wire logic [7:0] inc_val   = m + 8'h01;
    wire logic [7:0] rotl_val  = {m[6:0], m[RSSE_TOP_BIT]};
    wire logic [7:0] rotlc_val = {m[6:0], flags_q.c};
    wire logic [7:0] rotr_val  = {m[0], m[7:1]};
    wire logic [7:0] rotrc_val = {flags_q.c, m[7:1]};

    // subtractor shared by every subtract form
    wire logic       use_imm   = (exec_req_i.op == RSSE_OP_SBC_IMM);
    wire logic       use_brw   = (exec_req_i.op != RSSE_OP_SUB_MEM);
    wire logic [7:0] sub_b     = use_imm ? exec_req_i.imm : m;
    wire logic       brw_in    = use_brw & ~flags_q.c;
    wire logic [8:0] diff9     = {1'b0, acc_q} - {1'b0, sub_b} - {8'h00, brw_in};
    wire logic [4:0] half5     = {1'b0, acc_q[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, brw_in};
    wire logic [7:0] diff      = diff9[7:0];
    wire logic       sub_ov    = (acc_q[7] ^ sub_b[7]) & (acc_q[7] ^ diff[7]);
    wire logic       sub_z     = (diff == 8'h00);
    rsse_flags_t     sub_flags;

    // carry is an inverted borrow; chained zero keeps earlier zero for borrow forms
    assign sub_flags.c  = ~diff9[8];
    assign sub_flags.ac = ~half5[RSSE_HALF_BIT];
    assign sub_flags.ov = sub_ov;
    assign sub_flags.z  = sub_z;
    assign sub_flags.sc = sub_ov ^ diff[RSSE_TOP_BIT];
    assign sub_flags.cz = use_brw ? (sub_z & flags_q.cz) : sub_z;

    always_comb begin
        acc_d       = acc_q;
        flags_d     = flags_q;
        mem_we_d    = 1'b0;
        mem_wdata_d = mem_wdata_q;
        skip_d      = 1'b0;
        state_d     = RSSE_ST_EXEC;
        if (take) begin
            case (exec_req_i.op)
                RSSE_OP_ROTL_ACC: begin
                    acc_d = rotl_val;
                end
                RSSE_OP_ROTLC: begin
                    mem_we_d    = 1'b1;
                    mem_wdata_d = rotlc_val;
                    flags_d.c   = m[RSSE_TOP_BIT];
                end
                RSSE_OP_ROTLC_ACC: begin
                    acc_d     = rotlc_val;
                    flags_d.c = m[RSSE_TOP_BIT];
                end
                RSSE_OP_ROTR: begin
                    mem_we_d    = 1'b1;
                    mem_wdata_d = rotr_val;
                end
                RSSE_OP_ROTR_ACC: begin
                    acc_d = rotr_val;
                end
                RSSE_OP_ROTRC: begin
                    mem_we_d    = 1'b1;
                    mem_wdata_d = rotrc_val;
                    flags_d.c   = m[0];
                end
                RSSE_OP_ROTRC_ACC: begin
                    acc_d     = rotrc_val;
                    flags_d.c = m[0];
                end
                RSSE_OP_SBC_MEM, RSSE_OP_SBC_IMM, RSSE_OP_SUB_MEM: begin
                    acc_d   = diff;
                    flags_d = sub_flags;
                end
                RSSE_OP_SBC_TO_MEM: begin
                    mem_we_d    = 1'b1;
                    mem_wdata_d = diff;
                    flags_d     = sub_flags;
                end
                RSSE_OP_DSZ: begin
                    mem_we_d    = 1'b1;
                    mem_wdata_d = dec_val;
                    skip_d      = (dec_val == 8'h00);
                    state_d     = RSSE_ST_DUMMY;
                end
                RSSE_OP_DSZ_ACC: begin
                    acc_d   = dec_val;
                    skip_d  = (dec_val == 8'h00);
                    state_d = RSSE_ST_DUMMY;
                end
                RSSE_OP_ISZ: begin
                    mem_we_d    = 1'b1;
                    mem_wdata_d = inc_val;
                    skip_d      = (inc_val == 8'h00);
                    state_d     = RSSE_ST_DUMMY;
                end
                RSSE_OP_ISZ_ACC: begin
                    acc_d   = inc_val;
                    skip_d  = (inc_val == 8'h00);
                    state_d = RSSE_ST_DUMMY;
                end
                RSSE_OP_SNZ_BIT: begin
                    skip_d  = |(m & bit_mask);
                    state_d = RSSE_ST_DUMMY;
                end
                RSSE_OP_SNZ_BYTE: begin
                    // read-back write keeps any side effect of touching the byte
                    mem_we_d    = 1'b1;
                    mem_wdata_d = m;
                    skip_d      = (m != 8'h00);
                    state_d     = RSSE_ST_DUMMY;
                end
                RSSE_OP_SET_BYTE: begin
                    mem_we_d    = 1'b1;
                    mem_wdata_d = RSSE_ALL_ONES;
                end
                RSSE_OP_SET_BIT: begin
                    mem_we_d    = 1'b1;
                    mem_wdata_d = m | bit_mask;
                end
                default: begin
                    acc_d = acc_q;
                end
            endcase
        end else if (reg_wr_i) begin
            // software writes lose to a same-cycle execution
            if (reg_addr_i == RSSE_OFS_ACC) begin
                acc_d = reg_wdata_i;
            end
            if (reg_addr_i == RSSE_OFS_FLAGS) begin
                flags_d = reg_wdata_i[5:0];
            end
        end
    end

    assign rdata_d = !reg_rd_i                    ? 8'h00 :
                     (reg_addr_i == RSSE_OFS_ACC)   ? acc_q :
                     (reg_addr_i == RSSE_OFS_FLAGS) ? {2'b00, flags_q} : 8'h00;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q     <= RSSE_ST_EXEC;
            acc_q       <= RSSE_ACC_RST;
            flags_q     <= RSSE_FLAGS_RST;
            mem_we_q    <= 1'b0;
            mem_wdata_q <= 8'h00;
            skip_q      <= 1'b0;
            rdata_q     <= 8'h00;
        end else begin
            state_q     <= state_d;
            acc_q       <= acc_d;
            flags_q     <= flags_d;
            mem_we_q    <= mem_we_d;
            mem_wdata_q <= mem_wdata_d;
            skip_q      <= skip_d;
            rdata_q     <= rdata_d;
        end
    end

    // the dummy cycle blocks the next request while the skipped fetch happens
    assign exec_ready_o = (state_q == RSSE_ST_EXEC);
    assign mem_we_o     = mem_we_q;
    assign mem_wdata_o  = mem_wdata_q;
    assign skip_o       = skip_q;
    assign acc_o        = acc_q;
    assign flags_o      = flags_q;
    assign reg_rdata_o  = rdata_q;

    wire logic is_skip_op = exec_req_i.op inside {RSSE_OP_DSZ, RSSE_OP_DSZ_ACC, RSSE_OP_ISZ,
                            RSSE_OP_ISZ_ACC, RSSE_OP_SNZ_BIT, RSSE_OP_SNZ_BYTE};

    skip_two_cyc_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && is_skip_op |=> !exec_ready_o ##1 exec_ready_o)
        else $error("skip operation did not take exactly two cycles");

    single_cyc_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && !is_skip_op |=> exec_ready_o)
        else $error("non-skip operation stalled the port");

    rotl_acc_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_ROTL_ACC |=>
        acc_o == {$past(m[6:0]), $past(m[7])} && $stable(flags_o) && !mem_we_o)
        else $error("rotate left to accumulator wrong");

    rotlc_mem_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_ROTLC |=>
        mem_we_o && mem_wdata_o == {$past(m[6:0]), $past(flags_q.c)}
        && flags_o.c == $past(m[7]) && $stable(flags_o.z))
        else $error("rotate left through carry wrong");

    rotrc_acc_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_ROTRC_ACC |=>
        acc_o == {$past(flags_q.c), $past(m[7:1])} && flags_o.c == $past(m[0]) && !mem_we_o)
        else $error("rotate right through carry to accumulator wrong");

    sbc_carry_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_SBC_MEM |=>
        flags_o.c == ({1'b0, $past(acc_q)} >= {1'b0, $past(m)} + {8'h00, !$past(flags_q.c)}))
        else $error("subtract carry does not reflect borrow");

    sbc_result_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_SBC_IMM |=>
        acc_o == 8'($past(acc_q) - $past(exec_req_i.imm) - {7'h00, !$past(flags_q.c)}))
        else $error("subtract with borrow immediate wrong");

    dsz_skip_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_DSZ |=>
        mem_we_o && skip_o == ($past(m) == 8'h01) && $stable(flags_o))
        else $error("decrement skip wrong");

    snz_bit_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_SNZ_BIT |=>
        skip_o == $past(m[exec_req_i.bit_sel]) && !mem_we_o)
        else $error("bit test skip wrong");

    set_byte_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_SET_BYTE |=>
        mem_we_o && mem_wdata_o == 8'hff && $stable(flags_o))
        else $error("byte set wrong");

    rotlc_acc_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_ROTLC_ACC |=>
        acc_o == {$past(m[6:0]), $past(flags_q.c)} && flags_o.c == $past(m[7]) && !mem_we_o)
        else $error("rotate left through carry to accumulator wrong");

    rotr_mem_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_ROTR |=>
        mem_we_o && mem_wdata_o == {$past(m[0]), $past(m[7:1])} && $stable(flags_o))
        else $error("rotate right in memory wrong");

    rotr_acc_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_ROTR_ACC |=>
        acc_o == {$past(m[0]), $past(m[7:1])} && $stable(flags_o) && !mem_we_o)
        else $error("rotate right to accumulator wrong");

    rotrc_mem_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_ROTRC |=>
        mem_we_o && mem_wdata_o == {$past(flags_q.c), $past(m[7:1])} && flags_o.c == $past(m[0]))
        else $error("rotate right through carry in memory wrong");

    sbc_mem_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_SBC_MEM |=>
        acc_o == 8'($past(acc_q) - $past(m) - {7'h00, !$past(flags_q.c)}))
        else $error("subtract with borrow memory wrong");

    sbc_to_mem_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_SBC_TO_MEM |=>
        mem_we_o && mem_wdata_o == 8'($past(acc_q) - $past(m) - {7'h00, !$past(flags_q.c)})
        && $stable(acc_o))
        else $error("subtract with borrow to memory wrong");

    sub_zero_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op inside {RSSE_OP_SBC_MEM, RSSE_OP_SBC_IMM, RSSE_OP_SUB_MEM} |=>
        flags_o.z == (acc_o == 8'h00))
        else $error("subtract zero flag wrong");

    sub_plain_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_SUB_MEM |=>
        acc_o == 8'($past(acc_q) - $past(m)) && flags_o.c == ($past(acc_q) >= $past(m)))
        else $error("plain subtract wrong");

    dsz_acc_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_DSZ_ACC |=>
        acc_o == 8'($past(m) - 8'h01) && skip_o == (acc_o == 8'h00) && !mem_we_o)
        else $error("decrement to accumulator skip wrong");

    isz_mem_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_ISZ |=>
        mem_we_o && mem_wdata_o == 8'($past(m) + 8'h01) && skip_o == ($past(m) == 8'hff)
        && $stable(flags_o))
        else $error("increment skip wrong");

    isz_acc_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_ISZ_ACC |=>
        acc_o == 8'($past(m) + 8'h01) && skip_o == (acc_o == 8'h00) && !mem_we_o)
        else $error("increment to accumulator skip wrong");

    snz_byte_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_SNZ_BYTE |=>
        mem_we_o && mem_wdata_o == $past(m) && skip_o == ($past(m) != 8'h00))
        else $error("byte test skip wrong");

    set_bit_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        take && exec_req_i.op == RSSE_OP_SET_BIT |=>
        mem_we_o && mem_wdata_o == ($past(m) | (8'h01 << $past(exec_req_i.bit_sel)))
        && $stable(flags_o))
        else $error("bit set wrong");

    skip_pulse_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        skip_o |=> !skip_o)
        else $error("skip pulse longer than one cycle");

    dummy_drop_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !exec_ready_o |=> !mem_we_o && !skip_o)
        else $error("request taken in the dummy cycle");

endmodule : rsse_exec
`default_nettype wire

// ==== verif/rsse_exec_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rsse_pkg::*;

    logic        ref_clk_i;
    logic        resetn_i;
    logic        exec_valid_i;
    rsse_req_t   exec_req_i;
    logic        exec_ready_o;
    logic        mem_we_o;
    logic [7:0]  mem_wdata_o;
    logic        skip_o;
    logic [7:0]  acc_o;
    rsse_flags_t flags_o;
    logic [1:0]  reg_addr_i;
    logic [7:0]  reg_wdata_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [7:0]  reg_rdata_o;

    // reference model state
    logic [7:0]  m_acc, e_wd, e_rd;
    rsse_flags_t m_flags;
    logic        e_ready, e_we, e_skip;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;
    logic [31:0] seed = 32'ha1d4;
    logic [7:0]  vals [5] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hff};

    rsse_exec dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .exec_valid_i(exec_valid_i),
        .exec_req_i(exec_req_i), .exec_ready_o(exec_ready_o), .mem_we_o(mem_we_o),
        .mem_wdata_o(mem_wdata_o), .skip_o(skip_o), .acc_o(acc_o), .flags_o(flags_o),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));

    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return (s >> 1) ^ (s[0] ? 32'h80200003 : 32'h00000000);
    endfunction : lfsr

    task automatic fail(input string msg);
        mismatches++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask : fail

    task automatic print_verdict();
        if (mismatches == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic model_reset();
        m_acc = 8'h00; m_flags = rsse_flags_t'(6'h00);
        e_ready = 1'b1; e_we = 1'b0; e_skip = 1'b0; e_wd = 8'h00; e_rd = 8'h00;
    endtask : model_reset

    // outputs are sampled before this edge lands, then the model steps over it
    task automatic tick();
        logic [7:0] m, r;
        logic       c, taken, skipop;
        int         a, b, bin;
        @(posedge ref_clk_i);
        checked += 6;
        if (exec_ready_o !== e_ready) fail("ready");
        if (acc_o !== m_acc) fail("accumulator");
        if (flags_o !== m_flags) fail("flags");
        if (mem_we_o !== e_we || (e_we && mem_wdata_o !== e_wd)) fail("memory write");
        if (skip_o !== e_skip) fail("skip");
        if (reg_rdata_o !== e_rd) fail("read data");
        e_rd = !reg_rd_i ? 8'h00 : reg_addr_i == RSSE_OFS_ACC ? m_acc :
               reg_addr_i == RSSE_OFS_FLAGS ? {2'b00, m_flags} : 8'h00;
        taken = exec_valid_i && e_ready;
        e_we = 1'b0; e_skip = 1'b0; skipop = 1'b0;
        if (taken) begin
            m = exec_req_i.mem_data;
            c = m_flags.c;
            case (exec_req_i.op)
                RSSE_OP_ROTL_ACC: m_acc = {m[6:0], m[7]};
                RSSE_OP_ROTLC: begin e_we = 1'b1; e_wd = {m[6:0], c}; m_flags.c = m[7]; end
                RSSE_OP_ROTLC_ACC: begin m_acc = {m[6:0], c}; m_flags.c = m[7]; end
                RSSE_OP_ROTR: begin e_we = 1'b1; e_wd = {m[0], m[7:1]}; end
                RSSE_OP_ROTR_ACC: m_acc = {m[0], m[7:1]};
                RSSE_OP_ROTRC: begin e_we = 1'b1; e_wd = {c, m[7:1]}; m_flags.c = m[0]; end
                RSSE_OP_ROTRC_ACC: begin m_acc = {c, m[7:1]}; m_flags.c = m[0]; end
                RSSE_OP_SBC_MEM, RSSE_OP_SBC_IMM, RSSE_OP_SBC_TO_MEM, RSSE_OP_SUB_MEM: begin
                    a = m_acc;
                    b = exec_req_i.op == RSSE_OP_SBC_IMM ? exec_req_i.imm : m;
                    bin = exec_req_i.op == RSSE_OP_SUB_MEM ? 0 : !c;
                    r = 8'(a - b - bin);
                    m_flags.c = a >= b + bin;
                    m_flags.ac = (a % 16) >= (b % 16) + bin;
                    m_flags.z = r == 8'h00;
                    m_flags.ov = (m_acc[7] != b[7]) && (r[7] != m_acc[7]);
                    m_flags.sc = m_flags.ov ^ r[7];
                    m_flags.cz = m_flags.z & (bin == 0 && exec_req_i.op == RSSE_OP_SUB_MEM
                                              ? 1'b1 : m_flags.cz);
                    if (exec_req_i.op == RSSE_OP_SBC_TO_MEM) begin
                        e_we = 1'b1;
                        e_wd = r;
                    end else begin
                        m_acc = r;
                    end
                end
                RSSE_OP_DSZ: begin e_we = 1'b1; e_wd = m - 8'h01; e_skip = e_wd == 8'h00; end
                RSSE_OP_DSZ_ACC: begin m_acc = m - 8'h01; e_skip = m_acc == 8'h00; end
                RSSE_OP_ISZ: begin e_we = 1'b1; e_wd = m + 8'h01; e_skip = e_wd == 8'h00; end
                RSSE_OP_ISZ_ACC: begin m_acc = m + 8'h01; e_skip = m_acc == 8'h00; end
                RSSE_OP_SNZ_BIT: e_skip = m[exec_req_i.bit_sel];
                RSSE_OP_SNZ_BYTE: begin e_we = 1'b1; e_wd = m; e_skip = m != 8'h00; end
                RSSE_OP_SET_BYTE: begin e_we = 1'b1; e_wd = RSSE_ALL_ONES; end
                RSSE_OP_SET_BIT: begin e_we = 1'b1; e_wd = m | (8'h01 << exec_req_i.bit_sel); end
                default: ;
            endcase
            skipop = exec_req_i.op inside {RSSE_OP_DSZ, RSSE_OP_DSZ_ACC, RSSE_OP_ISZ,
                                           RSSE_OP_ISZ_ACC, RSSE_OP_SNZ_BIT, RSSE_OP_SNZ_BYTE};
        end else if (reg_wr_i && reg_addr_i == RSSE_OFS_ACC) begin
            m_acc = reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == RSSE_OFS_FLAGS) begin
            m_flags = rsse_flags_t'(reg_wdata_i[5:0]);
        end
        e_ready = !skipop;
    endtask : tick

    task automatic exec(input rsse_op_t op, input logic [2:0] bs, input logic [7:0] m,
                        input logic [7:0] im);
        exec_valid_i <= 1'b1;
        exec_req_i <= '{op, bs, m, im};
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        tick();
    endtask : exec

    task automatic regio(input logic wr, input logic [1:0] a, input logic [7:0] d);
        exec_valid_i <= 1'b0;
        reg_wr_i <= wr;
        reg_rd_i <= !wr;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        tick();
    endtask : regio

    task automatic do_reset();
        resetn_i <= 1'b0;
        exec_valid_i <= 1'b0;
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        model_reset();
    endtask : do_reset

    initial begin
        resetn_i = 1'b0; exec_valid_i = 1'b0; exec_req_i = '0;
        reg_addr_i = 2'h0; reg_wdata_i = 8'h00; reg_wr_i = 1'b0; reg_rd_i = 1'b0;
        model_reset();
        do_reset();
        // unmapped offsets read zero and ignore writes
        regio(1'b1, 2'h3, 8'h5a);
        for (int k = 0; k < 4; k++) regio(1'b0, 2'(k), 8'h00);
        // every operation against boundary data, carry clear and set; a request in
        // the dummy slot of a skip operation must be dropped
        for (int c = 0; c < 2; c++) begin
            for (int o = 0; o < 20; o++) begin
                for (int k = 0; k < 5; k++) begin
                    regio(1'b1, RSSE_OFS_FLAGS, c ? 8'h3f : 8'h00);
                    regio(1'b1, RSSE_OFS_ACC, vals[(k + c + 1) % 5]);
                    exec(rsse_op_t'(o), 3'(k * 3 + c), vals[k], vals[4 - k]);
                    exec(RSSE_OP_SET_BIT, 3'(k), vals[(k + 2) % 5], 8'h00);
                end
            end
        end
        // random traffic, back to back, register writes colliding with execution
        repeat (3000) begin
            seed = lfsr(seed);
            exec_valid_i <= seed[0] | seed[1];
            exec_req_i <= '{rsse_op_t'(seed[8:4] % 5'd20), seed[11:9],
                            seed[21:20] == 2'h0 ? 8'h00 : seed[21:20] == 2'h1 ? 8'hff
                                                : seed[19:12], seed[31:24]};
            reg_wr_i <= seed[2] & seed[3];
            reg_rd_i <= !(seed[2] & seed[3]) && !(seed[0] | seed[1]);
            reg_addr_i <= seed[23:22];
            reg_wdata_i <= seed[31:24];
            tick();
        end
        // reset in mid-run clears everything again
        regio(1'b1, RSSE_OFS_ACC, 8'ha5);
        do_reset();
        regio(1'b0, RSSE_OFS_ACC, 8'h00);
        regio(1'b0, RSSE_OFS_FLAGS, 8'h00);
        tick();
        print_verdict();
    end
endmodule : tb
`default_nettype wire
